// >>> prwsc_pkg.sv
package prwsc_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RST_MIN_MS = 4;
  localparam int unsigned RST_EXT_MS = 128;
  localparam int unsigned TICK_MS_CYC = CLK_HZ / 1000;
  localparam int unsigned RST_MIN_TICKS = RST_MIN_MS;
  localparam int unsigned RST_EXT_TICKS = RST_EXT_MS;
  localparam int unsigned MS_CNT_W = 16;
  localparam int unsigned TICK_CNT_W = 8;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [1:0] SUSP_MODE_RST = 2'h2;
  localparam logic [1:0] WAKE_STS_RST = 2'h0;
  localparam logic XTAL_DIS_DEFAULT = 1'h1;
  // Suspend mode encodings
  localparam logic [1:0] SUSP_LIGHT = 2'h0;
  localparam logic [1:0] SUSP_ONE = 2'h1;
  localparam logic [1:0] SUSP_PHY_OFF = 2'h2;
  localparam logic [1:0] SUSP_ACTIVE_ENERGY = 2'h3;
  // Status field bit positions
  localparam int unsigned STS_PHY_BIT = 0;
  localparam int unsigned STS_LAN_BIT = 1;
  // Power states reported by the sequencer
  typedef enum logic [2:0] {
    PRWSC_PS_UNCONF,
    PRWSC_PS_CONF,
    PRWSC_PS_SUSPEND
  } prwsc_pstate_e;
endpackage : prwsc_pkg

// >>> prwsc_ms_tick.sv
`timescale 1ns/1ps
// Millisecond tick divider: one-cycle enable every CYC cycles while run
module prwsc_ms_tick #(
  // Cycles per tick; a smaller value only shortens simulation runs
  parameter int unsigned CYC = prwsc_pkg::TICK_MS_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Control
  input wire logic run_in,
  // Tick
  output logic tick_out
);
  logic [prwsc_pkg::MS_CNT_W-1:0] cnt_q;
  logic [prwsc_pkg::MS_CNT_W-1:0] cnt_d;
  logic wrap;

  // Restart on every run to give a full first millisecond
  assign wrap = (cnt_q == prwsc_pkg::MS_CNT_W'(CYC - 1));
  assign cnt_d = (!run_in || wrap) ? '0 : cnt_q + 1'b1;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_out <= run_in && wrap;
    end
  end
endmodule : prwsc_ms_tick

// >>> prwsc_ctl.sv
`timescale 1ns/1ps
module prwsc_ctl #(
  // Clock cycles per millisecond tick
  parameter int unsigned TICK_CYC = prwsc_pkg::TICK_MS_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // USB or lite soft reset, synchronous pulse
  input wire logic lite_soft_reset_in,
  // Software writes
  input wire logic phy_reset_ctl_wr_in,
  input wire logic skip_analog_ref_wait_in,
  input wire logic wake_en_wr_in,
  input wire logic lan_wake_enable_in,
  input wire logic phy_irq_wake_enable_in,
  input wire logic resume_clears_wake_enables_in,
  input wire logic resume_clears_wake_status_in,
  input wire logic sts_wr_in,
  input wire logic [1:0] wake_cause_status_clr_in,
  input wire logic energy_wake_qualifier_clr_in,
  input wire logic susp_mode_wr_in,
  input wire logic [1:0] suspend_mode_in,
  // Configuration image
  input wire logic image_load_done_in,
  input wire logic image_valid_in,
  input wire logic image_crystal_suspend_disable_in,
  input wire logic external_phy_in,
  // Power sequencer
  input wire logic unconfigured_in,
  input wire logic in_suspend_in,
  input wire logic resume_done_in,
  input wire logic remote_resume_in,
  // Wake events, one-cycle pulses; PHY operational status level
  input wire logic phy_irq_in,
  input wire logic lan_event_in,
  input wire logic energy_rx_wake_in,
  input wire logic energy_tx_wake_in,
  input wire logic phy_operational_in,
  // Outputs
  output logic phy_reset_out,
  output logic phy_reset_ctl_out,
  output logic device_ready_out,
  output logic lan_wake_enable_out,
  output logic phy_irq_wake_enable_out,
  output logic [1:0] wake_cause_status_out,
  output logic energy_wake_qualifier_out,
  output logic [1:0] suspend_mode_out,
  output logic crystal_suspend_disable_out
);
  // ------------------------------------------------------------
  // Reset timer
  // ------------------------------------------------------------
  logic ms_tick;
  logic [prwsc_pkg::TICK_CNT_W-1:0] ms_cnt_q;
  logic [prwsc_pkg::TICK_CNT_W-1:0] ms_cnt_d;
  logic [prwsc_pkg::TICK_CNT_W-1:0] ms_goal;
  logic sw_rst_q;
  logic sw_rst_d;
  logic sw_start;
  logic sw_done;
  logic hold_rst;
  logic phy_reset_ctl_d;
  logic ready_d;
  logic ready_q;
  logic was_rst_q;

  prwsc_ms_tick #(.CYC(TICK_CYC)) u_tick (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .run_in(sw_rst_q),
    .tick_out(ms_tick)
  );

  // Write only takes effect while idle, so the interval cannot restart
  assign sw_start = phy_reset_ctl_wr_in && !sw_rst_q;
  // Analog wait stretches the interval to the long figure
  assign ms_goal = skip_analog_ref_wait_in ?
    prwsc_pkg::TICK_CNT_W'(prwsc_pkg::RST_MIN_TICKS) :
    prwsc_pkg::TICK_CNT_W'(prwsc_pkg::RST_EXT_TICKS);
  assign sw_done = sw_rst_q && ms_tick &&
    (ms_cnt_q + 1'b1 >= ms_goal);
  assign ms_cnt_d = !sw_rst_q ? '0 : (ms_tick ? ms_cnt_q + 1'b1 : ms_cnt_q);
  assign sw_rst_d = sw_start ? 1'b1 : (sw_done ? 1'b0 : sw_rst_q);

  // Internal PHY is held in reset while unconfigured or suspended
  assign hold_rst = !external_phy_in &&
    (unconfigured_in || in_suspend_in);
  assign phy_reset_ctl_d = sw_rst_d || hold_rst;

  // ------------------------------------------------------------
  // Ready tracking
  // ------------------------------------------------------------
  // External PHY: ready follows image load, dropped during software reset; suspend never drops it
  assign ready_d = external_phy_in ?
    (image_load_done_in && !sw_rst_d) :
    (!phy_reset_ctl_d && !phy_reset_out && phy_operational_in &&
     (ready_q || was_rst_q || !unconfigured_in));

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sw_rst_q <= 1'b0;
      ms_cnt_q <= '0;
      phy_reset_out <= 1'b1;
      phy_reset_ctl_out <= 1'b0;
      ready_q <= 1'b0;
      device_ready_out <= 1'b0;
      was_rst_q <= 1'b0;
    end
    else
    begin
      sw_rst_q <= sw_rst_d;
      ms_cnt_q <= ms_cnt_d;
      phy_reset_out <= phy_reset_ctl_d;
      phy_reset_ctl_out <= sw_rst_d;
      ready_q <= ready_d;
      device_ready_out <= ready_d;
      was_rst_q <= phy_reset_ctl_d || (was_rst_q && !ready_d);
    end
  end

  // ------------------------------------------------------------
  // Wake enables, status and configuration
  // ------------------------------------------------------------
  logic clr_en;
  logic clr_sts;
  logic [1:0] sts_set;
  logic qual_set;
  logic [1:0] sts_d;
  logic qual_d;
  logic lan_en_d;
  logic phy_en_d;
  logic rx_ok;
  logic tx_ok;
  logic img_xtal;

  // Only resumes started by a remote wake clear anything
  assign clr_en = resume_done_in && remote_resume_in &&
    resume_clears_wake_enables_in;
  assign clr_sts = resume_done_in && remote_resume_in &&
    resume_clears_wake_status_in;
  assign lan_en_d = clr_en ? 1'b0 :
    (wake_en_wr_in ? lan_wake_enable_in : lan_wake_enable_out);
  assign phy_en_d = clr_en ? 1'b0 :
    (wake_en_wr_in ? phy_irq_wake_enable_in : phy_irq_wake_enable_out);

  // Status sets from events alone; the upstream filter gates per power state
  assign sts_set[prwsc_pkg::STS_PHY_BIT] = phy_irq_in;
  assign sts_set[prwsc_pkg::STS_LAN_BIT] = lan_event_in;
  assign rx_ok = (suspend_mode_out == prwsc_pkg::SUSP_LIGHT) ||
    (suspend_mode_out == prwsc_pkg::SUSP_ACTIVE_ENERGY);
  assign tx_ok = (suspend_mode_out == prwsc_pkg::SUSP_ACTIVE_ENERGY);
  assign qual_set = (energy_rx_wake_in && rx_ok) ||
    (energy_tx_wake_in && tx_ok);

  // A set arriving with a clear wins so no event is lost
  assign sts_d[prwsc_pkg::STS_PHY_BIT] = sts_set[prwsc_pkg::STS_PHY_BIT] ||
    (wake_cause_status_out[prwsc_pkg::STS_PHY_BIT] &&
     !(sts_wr_in && wake_cause_status_clr_in[prwsc_pkg::STS_PHY_BIT]));
  assign sts_d[prwsc_pkg::STS_LAN_BIT] = sts_set[prwsc_pkg::STS_LAN_BIT] ||
    (wake_cause_status_out[prwsc_pkg::STS_LAN_BIT] && !clr_sts &&
     !(sts_wr_in && wake_cause_status_clr_in[prwsc_pkg::STS_LAN_BIT]));
  assign qual_d = qual_set || (energy_wake_qualifier_out && !clr_sts &&
    !(sts_wr_in && energy_wake_qualifier_clr_in));

  assign img_xtal = image_valid_in ? image_crystal_suspend_disable_in :
    prwsc_pkg::XTAL_DIS_DEFAULT;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      lan_wake_enable_out <= 1'b0;
      phy_irq_wake_enable_out <= 1'b0;
      wake_cause_status_out <= prwsc_pkg::WAKE_STS_RST;
      energy_wake_qualifier_out <= 1'b0;
      suspend_mode_out <= prwsc_pkg::SUSP_MODE_RST;
      crystal_suspend_disable_out <= prwsc_pkg::XTAL_DIS_DEFAULT;
    end
    else
    begin
      lan_wake_enable_out <= lan_en_d;
      phy_irq_wake_enable_out <= phy_en_d;
      wake_cause_status_out <= sts_d;
      energy_wake_qualifier_out <= qual_d;
      // Unconfigured forces the phy-off variant, the only legal choice there
      if (unconfigured_in)
        suspend_mode_out <= prwsc_pkg::SUSP_MODE_RST;
      else if (susp_mode_wr_in)
        suspend_mode_out <= suspend_mode_in;
      if (lite_soft_reset_in || image_load_done_in)
        crystal_suspend_disable_out <= img_xtal;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [7:0] rst_len_q;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rst_len_q <= '0;
    else if (!sw_rst_q)
      rst_len_q <= '0;
    else if (ms_tick && rst_len_q != 8'hFF)
      rst_len_q <= rst_len_q + 8'h01;
  end

  rst_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (phy_reset_ctl_wr_in && !sw_rst_q) |=> (phy_reset_out && phy_reset_ctl_out))
    else $error("PHY reset not asserted after write");
  rst_min_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(sw_rst_q) |-> ($past(rst_len_q) >= 8'h03))
    else $error("PHY reset released before 4 ms");
  rst_ext_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ($fell(sw_rst_q) && !skip_analog_ref_wait_in) |-> ($past(rst_len_q) >= 8'h7F))
    else $error("PHY reset not stretched");
  rst_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    phy_reset_ctl_out |-> sw_rst_q)
    else $error("Reset control bit outlives reset");
  rst_norestart_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sw_rst_q && phy_reset_ctl_wr_in && !ms_tick) |=> (ms_cnt_q == $past(ms_cnt_q)))
    else $error("Reset interval restarted");
  ready_drop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    phy_reset_ctl_out |-> !device_ready_out)
    else $error("Ready high during PHY reset");
  en_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    clr_en |=> (!lan_wake_enable_out && !phy_irq_wake_enable_out))
    else $error("Wake enables not cleared on resume");
  sts_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    phy_irq_in |=> wake_cause_status_out[0])
    else $error("PHY wake status lost");
  sts_resume_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (clr_sts && !lan_event_in) |=> !wake_cause_status_out[1])
    else $error("LAN status not cleared on resume");
  int_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!external_phy_in && unconfigured_in) |=> phy_reset_out)
    else $error("Internal PHY not held in reset");
  ext_keep_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (external_phy_in && image_load_done_in && !sw_rst_d) |=> device_ready_out)
    else $error("External PHY ready dropped");

  // ------------------------------------------------------------
  // Checks on release, ready and stored fields
  // ------------------------------------------------------------
  // Control bit and PHY reset must let go on the same edge
  rst_release_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ($fell(phy_reset_ctl_out) && !$past(hold_rst)) |-> $fell(phy_reset_out))
    else $error("Control bit and PHY reset fell apart");
  rst_keep_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sw_rst_q && phy_reset_ctl_wr_in && !ms_tick) |=> (rst_len_q == $past(rst_len_q)))
    else $error("Reset length disturbed by write");
  // Internal ready only follows an operational PHY out of reset
  ready_op_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!$past(external_phy_in) && device_ready_out) |->
      (!phy_reset_out && $past(phy_operational_in)))
    else $error("Internal ready without operational PHY");
  int_unconf_ready_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!external_phy_in && unconfigured_in) |=> !device_ready_out)
    else $error("Ready high while internal PHY unconfigured");
  int_suspend_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!external_phy_in && in_suspend_in) |=> (phy_reset_out && !device_ready_out))
    else $error("Internal PHY not held in suspend");
  ext_suspend_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (external_phy_in && !sw_rst_d) |=> !phy_reset_out)
    else $error("External PHY reset without request");
  ready_ext_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (external_phy_in && !image_load_done_in) |=> !device_ready_out)
    else $error("External ready before image load");
  // Wake enables
  lan_en_wr_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wake_en_wr_in && !clr_en) |=> (lan_wake_enable_out == $past(lan_wake_enable_in)))
    else $error("LAN wake enable write lost");
  phy_en_wr_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wake_en_wr_in && !clr_en) |=> (phy_irq_wake_enable_out == $past(phy_irq_wake_enable_in)))
    else $error("PHY wake enable write lost");
  en_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!wake_en_wr_in && !clr_en) |=>
      ($stable(lan_wake_enable_out) && $stable(phy_irq_wake_enable_out)))
    else $error("Wake enables changed without cause");
  // Wake status and qualifier
  sts_lan_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    lan_event_in |=> wake_cause_status_out[1])
    else $error("LAN wake status lost");
  sts_w1c_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sts_wr_in && wake_cause_status_clr_in[0] && !phy_irq_in) |=> !wake_cause_status_out[0])
    else $error("PHY wake status not cleared");
  sts_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wake_cause_status_out[0] && !(sts_wr_in && wake_cause_status_clr_in[0])) |=>
      wake_cause_status_out[0])
    else $error("PHY wake status dropped");
  sts_lan_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wake_cause_status_out[1] && !clr_sts && !(sts_wr_in && wake_cause_status_clr_in[1])) |=>
      wake_cause_status_out[1])
    else $error("LAN wake status dropped");
  qual_rx_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (energy_rx_wake_in && (suspend_mode_out == prwsc_pkg::SUSP_LIGHT ||
      suspend_mode_out == prwsc_pkg::SUSP_ACTIVE_ENERGY)) |=> energy_wake_qualifier_out)
    else $error("Receive energy wake not flagged");
  qual_tx_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (energy_tx_wake_in && suspend_mode_out == prwsc_pkg::SUSP_ACTIVE_ENERGY) |=>
      energy_wake_qualifier_out)
    else $error("Transmit energy wake not flagged");
  qual_light_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!energy_wake_qualifier_out && !energy_rx_wake_in &&
      suspend_mode_out == prwsc_pkg::SUSP_LIGHT) |=> !energy_wake_qualifier_out)
    else $error("Transmit wake flagged in light suspend");
  qual_resume_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (clr_sts && !energy_rx_wake_in && !energy_tx_wake_in) |=> !energy_wake_qualifier_out)
    else $error("Qualifier not cleared on resume");
  // Suspend mode and crystal image
  susp_unconf_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    unconfigured_in |=> (suspend_mode_out == prwsc_pkg::SUSP_MODE_RST))
    else $error("Suspend mode not forced when unconfigured");
  susp_write_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!unconfigured_in && susp_mode_wr_in) |=> (suspend_mode_out == $past(suspend_mode_in)))
    else $error("Suspend mode write lost");
  susp_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!unconfigured_in && !susp_mode_wr_in) |=> $stable(suspend_mode_out))
    else $error("Suspend mode changed without write");
  xtal_reload_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (lite_soft_reset_in || image_load_done_in) |=>
      (crystal_suspend_disable_out == $past(img_xtal)))
    else $error("Crystal field not reloaded");
endmodule : prwsc_ctl

// >>> prwsc_phy_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// PHY model
// ----------------------------------------
// Becomes operational DLY cycles after its reset is released
module prwsc_phy_model #(
  parameter int DLY = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Reset from the device
  input wire logic phy_reset_in,
  // Status to the device
  output logic phy_operational_out
);
  int cnt_q;
  // A real PHY needs start-up time, so ready must not follow reset release at once
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_q <= 0;
    end
    else if (phy_reset_in)
    begin
      cnt_q <= 0;
    end
    else if (cnt_q < DLY)
    begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign phy_operational_out = (cnt_q == DLY);
endmodule : prwsc_phy_model

// >>> test_phy_reset_wake_status_ctl.sv
`timescale 1ns/1ps
module test_phy_reset_wake_status_ctl;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_in = 1'b0, rstn_in = 1'b0, lite_soft_reset_in = 1'b0, phy_reset_ctl_wr_in = 1'b0;
  logic skip_analog_ref_wait_in = 1'b1, wake_en_wr_in = 1'b0, lan_wake_enable_in = 1'b0;
  logic phy_irq_wake_enable_in = 1'b0, resume_clears_wake_enables_in = 1'b0;
  logic resume_clears_wake_status_in = 1'b0, sts_wr_in = 1'b0, energy_wake_qualifier_clr_in = 1'b0;
  logic [1:0] wake_cause_status_clr_in = 2'h0, suspend_mode_in = 2'h0;
  logic susp_mode_wr_in = 1'b0, image_load_done_in = 1'b0, image_valid_in = 1'b0;
  logic image_crystal_suspend_disable_in = 1'b0, external_phy_in = 1'b0, unconfigured_in = 1'b1;
  logic in_suspend_in = 1'b0, resume_done_in = 1'b0, remote_resume_in = 1'b0, phy_irq_in = 1'b0;
  logic lan_event_in = 1'b0, energy_rx_wake_in = 1'b0, energy_tx_wake_in = 1'b0;
  logic phy_operational_in, phy_reset_out, phy_reset_ctl_out, device_ready_out;
  logic lan_wake_enable_out, phy_irq_wake_enable_out, energy_wake_qualifier_out;
  logic crystal_suspend_disable_out;
  logic [1:0] wake_cause_status_out, suspend_mode_out;
  int n_mismatch = 0, check_count = 0;
  // Short tick keeps the long reset inside the run budget
  localparam int TICK = 100;
  // Half period of the 40 MHz clock
  always #12.5 clk_in = ~clk_in;
  prwsc_ctl #(.TICK_CYC(TICK)) DUT (.clk_in, .rstn_in, .lite_soft_reset_in, .phy_reset_ctl_wr_in,
    .skip_analog_ref_wait_in, .wake_en_wr_in, .lan_wake_enable_in, .phy_irq_wake_enable_in,
    .resume_clears_wake_enables_in, .resume_clears_wake_status_in, .sts_wr_in,
    .wake_cause_status_clr_in, .energy_wake_qualifier_clr_in, .susp_mode_wr_in,
    .suspend_mode_in, .image_load_done_in, .image_valid_in, .image_crystal_suspend_disable_in,
    .external_phy_in, .unconfigured_in, .in_suspend_in, .resume_done_in, .remote_resume_in,
    .phy_irq_in, .lan_event_in, .energy_rx_wake_in, .energy_tx_wake_in, .phy_operational_in,
    .phy_reset_out, .phy_reset_ctl_out, .device_ready_out, .lan_wake_enable_out,
    .phy_irq_wake_enable_out, .wake_cause_status_out, .energy_wake_qualifier_out,
    .suspend_mode_out, .crystal_suspend_disable_out);
  prwsc_phy_model PHY (.clk_in, .rstn_in, .phy_reset_in(phy_reset_out),
    .phy_operational_out(phy_operational_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask : cyc
  task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One-cycle strobe, then one more cycle so the registered answer has landed
  task automatic wr(input int k, input logic [1:0] d);
    case (k)
      0: phy_reset_ctl_wr_in = 1'b1;
      1: {wake_en_wr_in, lan_wake_enable_in, phy_irq_wake_enable_in} = {1'b1, d};
      2: {sts_wr_in, wake_cause_status_clr_in} = {1'b1, d};
      3: {sts_wr_in, energy_wake_qualifier_clr_in} = 2'h3;
      4: {susp_mode_wr_in, suspend_mode_in} = {1'b1, d};
      5: phy_irq_in = 1'b1;
      6: lan_event_in = 1'b1;
      7: energy_rx_wake_in = 1'b1;
      8: energy_tx_wake_in = 1'b1;
      9: resume_done_in = 1'b1;
      default: lite_soft_reset_in = 1'b1;
    endcase
    @(negedge clk_in);
    {phy_reset_ctl_wr_in, wake_en_wr_in, sts_wr_in, susp_mode_wr_in, phy_irq_in} = 5'h00;
    {lan_event_in, energy_rx_wake_in, energy_tx_wake_in, resume_done_in} = 4'h0;
    {lite_soft_reset_in, energy_wake_qualifier_clr_in, wake_cause_status_clr_in} = 4'h0;
    @(negedge clk_in);
  endtask : wr
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // Watchdog sized for the 128-tick reset plus about twice the margin
  initial
  begin
    repeat (30000) @(posedge clk_in);
    n_mismatch++;
    $display("[ERR] watchdog expected done seen timeout");
    tally_and_finish();
  end
  initial
  begin
    cyc(12);
    rstn_in = 1'b1;
    cyc(2);
    chk("enables", 2'h0, {lan_wake_enable_out, phy_irq_wake_enable_out});
    chk("status", 2'h0, wake_cause_status_out);
    chk("mode", 2'h2, suspend_mode_out);
    chk("ctl", 2'h0, {1'b0, phy_reset_ctl_out});
    chk("unconf reset ready", 2'h2, {phy_reset_out, device_ready_out});
    chk("crystal", 2'h1, {1'b0, crystal_suspend_disable_out});
    {image_valid_in, image_crystal_suspend_disable_in} = 2'h2;
    wr(10, 2'h0);
    chk("crystal image", 2'h0, {1'b0, crystal_suspend_disable_out});
    image_valid_in = 1'b0;
    wr(10, 2'h0);
    chk("crystal none", 2'h1, {1'b0, crystal_suspend_disable_out});
    $display("test reset_values done");
    {external_phy_in, image_load_done_in} = 2'h3;
    cyc(3);
    chk("ext ready", 2'h1, {1'b0, device_ready_out});
    unconfigured_in = 1'b0;
    cyc(3);
    chk("ext conf ready", 2'h1, {1'b0, device_ready_out});
    wr(4, 2'h2);
    in_suspend_in = 1'b1;
    cyc(3);
    chk("ext suspend", 2'h1, {phy_reset_out, device_ready_out});
    in_suspend_in = 1'b0;
    $display("test ready_external done");
    wr(1, 2'h3);
    chk("enables set", 2'h3, {lan_wake_enable_out, phy_irq_wake_enable_out});
    wr(1, 2'h0);
    wr(5, 2'h0);
    chk("phy wake", 2'h1, wake_cause_status_out);
    wr(6, 2'h0);
    chk("both wakes", 2'h3, wake_cause_status_out);
    wr(2, 2'h1);
    chk("w1c bit0", 2'h2, wake_cause_status_out);
    wr(2, 2'h2);
    chk("w1c bit1", 2'h0, wake_cause_status_out);
    wr(4, 2'h0);
    wr(8, 2'h0);
    chk("tx light", 2'h0, {1'b0, energy_wake_qualifier_out});
    wr(7, 2'h0);
    chk("rx light", 2'h1, {1'b0, energy_wake_qualifier_out});
    wr(3, 2'h0);
    chk("qual w1c", 2'h0, {1'b0, energy_wake_qualifier_out});
    wr(4, 2'h3);
    chk("mode write", 2'h3, suspend_mode_out);
    wr(8, 2'h0);
    chk("tx active", 2'h1, {1'b0, energy_wake_qualifier_out});
    $display("test wake_status done");
    wr(1, 2'h3);
    wr(6, 2'h0);
    wr(5, 2'h0);
    {resume_clears_wake_enables_in, resume_clears_wake_status_in} = 2'h3;
    wr(9, 2'h0);
    chk("host resume", 2'h3, {lan_wake_enable_out, phy_irq_wake_enable_out});
    remote_resume_in = 1'b1;
    wr(9, 2'h0);
    chk("resume enables", 2'h0, {lan_wake_enable_out, phy_irq_wake_enable_out});
    chk("resume status", 2'h1, wake_cause_status_out);
    chk("resume qual", 2'h0, {1'b0, energy_wake_qualifier_out});
    $display("test resume done");
    wr(0, 2'h0);
    chk("reset start", 2'h3, {phy_reset_out, phy_reset_ctl_out});
    chk("ready drop", 2'h0, {1'b0, device_ready_out});
    // Release falls four ticks and one cycle after the taking edge
    cyc(2 * TICK);
    wr(0, 2'h0);
    cyc(2 * TICK - 3);
    chk("reset held", 2'h3, {phy_reset_out, phy_reset_ctl_out});
    cyc(1);
    chk("reset end", 2'h0, {phy_reset_out, phy_reset_ctl_out});
    cyc(12);
    chk("ready back", 2'h1, {1'b0, device_ready_out});
    $display("test phy_reset done");
    skip_analog_ref_wait_in = 1'b0;
    wr(0, 2'h0);
    cyc(4 * TICK);
    chk("reset stretched", 2'h3, {phy_reset_out, phy_reset_ctl_out});
    cyc(124 * TICK - 1);
    chk("long held", 2'h3, {phy_reset_out, phy_reset_ctl_out});
    cyc(1);
    chk("long end", 2'h0, {phy_reset_out, phy_reset_ctl_out});
    skip_analog_ref_wait_in = 1'b1;
    $display("test long_reset done");
    external_phy_in = 1'b0;
    unconfigured_in = 1'b1;
    cyc(2);
    chk("int unconf", 2'h2, {phy_reset_out, device_ready_out});
    chk("mode unconf", 2'h2, suspend_mode_out);
    unconfigured_in = 1'b0;
    cyc(3);
    chk("int wait", 2'h0, {phy_reset_out, device_ready_out});
    cyc(12);
    chk("int ready", 2'h1, {phy_reset_out, device_ready_out});
    in_suspend_in = 1'b1;
    cyc(2);
    chk("int suspend", 2'h2, {phy_reset_out, device_ready_out});
    in_suspend_in = 1'b0;
    cyc(3);
    chk("int resume wait", 2'h0, {phy_reset_out, device_ready_out});
    cyc(12);
    chk("int resume ready", 2'h1, {phy_reset_out, device_ready_out});
    $display("test ready_internal done");
    tally_and_finish();
  end
endmodule : test_phy_reset_wake_status_ctl
